// >>> pkg/fmc_consts.vh
`ifndef FMC_CONSTS_VH
`define FMC_CONSTS_VH
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FMC_B_WE        0
`define FMC_B_EE        1
`define FMC_B_BUSY      2
`define FMC_B_PROT      2
`define FMC_B_FAULT     3
`define FMC_B_SUPPLY    4
`define FMC_B_TMR_LO    5
`define FMC_B_TMR_HI    6
`define FMC_B_DWORD     7
`define FMC_B_BANK_LO   8
`define FMC_B_BANK_HI   9
`define FMC_B_WMODE     15
`define FMC_RESET_VAL   16'h0000
`define FMC_PROT_RESET  1'b1
// ----------------------------------------
// Bank bounds (word address space, byte address)
// ----------------------------------------
`define FMC_BANK0_END   15'h2fff
`define FMC_BANK1_END   15'h5fff
`define FMC_BANK2_END   15'h77ff
`define FMC_BANK3_END   15'h7fff
`define FMC_BANK1_BASE  15'h3000
`define FMC_BANK2_BASE  15'h6000
`define FMC_BANK3_BASE  15'h7800
// ----------------------------------------
// Pulse timer counts in CPU clock periods
// ----------------------------------------
`define FMC_PULSE_DURATION_0      20'd400
`define FMC_PULSE_DURATION_1      20'd4000
`define FMC_PULSE_DURATION_2      20'd40000
`define FMC_PULSE_DURATION_3      20'd400000
`endif

// >>> core/fmc_pulse_timer.v
`default_nettype none
module fmc_pulse_timer
(
   // Clock and reset
   input  wire        clk_sys_i,
   input  wire        reset_i,
   // Control
   input  wire        start_i,
   input  wire [19:0] count_i,
   // Status
   output reg         done_o
);
`include "fmc_consts.vh"

   reg  [19:0] cnt_q;
   reg         run_q;

   always @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         cnt_q  <= 20'h00000;
         run_q  <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            cnt_q <= count_i - 20'h00001;
            run_q <= 1'b1;
         end
         else if (run_q)
         begin
            if (cnt_q == 20'h00000)
            begin
               run_q  <= 1'b0;
               done_o <= 1'b1;
            end
            else
               cnt_q <= cnt_q - 20'h00001;
         end
      end
   end
endmodule // fmc_pulse_timer
`default_nettype wire

// >>> core/fmc_sync2.v
`default_nettype none
module fmc_sync2
(
   // Clock and reset
   input  wire clk_sys_i,
   input  wire reset_i,
   // Async level in, synced out
   input  wire async_i,
   output reg  sync_o
);
   reg meta_q;

   always @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // fmc_sync2
`default_nettype wire

// >>> core/fmc_flash_ctrl.v
`default_nettype none
module fmc_flash_ctrl
(
   // Clock and reset
   input  wire        clk_sys_i,
   input  wire        reset_i,
   // CPU access request
   input  wire        acc_valid_i,
   input  wire        acc_write_i,
   input  wire        acc_direct_i,
   input  wire        acc_from_flash_i,
   input  wire [14:0] acc_addr_i,
   input  wire [15:0] acc_wdata_i,
   // CPU access answer
   output reg         acc_ack_o,
   output reg         acc_err_o,
   output reg  [15:0] acc_rdata_o,
   // Array port
   input  wire [15:0] arr_rdata_i,
   output reg         arr_rd_o,
   output reg  [14:0] arr_addr_o,
   // Array operation
   output reg         arr_prog_o,
   output reg         arr_erase_o,
   output reg  [1:0]  arr_bank_o,
   output reg  [14:0] arr_erase_lo_o,
   output reg  [14:0] arr_erase_hi_o,
   output reg  [31:0] arr_prog_data_o,
   output reg         arr_dword_o,
   output reg         arr_pverify_o,
   output reg         arr_everify_o,
   // Option and supply pins
   input  wire        prot_option_i,
   input  wire        supply_ok_i,
   // Status
   output reg         write_mode_o,
   output reg         prot_active_o
);
`include "fmc_consts.vh"

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_WAIT2 = 4'b0010;
   localparam [3:0] ST_RUN  = 4'b0100;
   localparam [3:0] ST_VER  = 4'b1000;

   reg  [3:0]  state_q;
   reg         wmode_q;
   reg         we_q;
   reg         ee_q;
   reg  [1:0]  bank_q;
   reg         dword_q;
   reg  [1:0]  tmr_q;
   reg         fault_q;
   reg         busy_q;
   reg         prot_q;
   reg         unlock_q;
   reg         half_q;
   reg  [15:0] lo_word_q;
   reg  [14:0] op_addr_q;
   reg         start_q;
   reg  [19:0] tcount_q;
   reg         op_live;
   wire        supply_s;
   wire        tmr_done;
   wire        prot_act;
   wire        blocked;
   wire        even;
   wire [15:0] ctl_rd;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [19:0] pulse_duration;
      input [1:0] sel;
      begin
         if (sel == 2'b00)
            pulse_duration = `FMC_PULSE_DURATION_0;
         else if (sel == 2'b01)
            pulse_duration = `FMC_PULSE_DURATION_1;
         else if (sel == 2'b10)
            pulse_duration = `FMC_PULSE_DURATION_2;
         else
            pulse_duration = `FMC_PULSE_DURATION_3;
      end
   endfunction

   function [29:0] bank_range;
      input [1:0] b;
      begin
         if (b == 2'b00)
            bank_range = {15'h0000, `FMC_BANK0_END};
         else if (b == 2'b01)
            bank_range = {`FMC_BANK1_BASE, `FMC_BANK1_END};
         else if (b == 2'b10)
            bank_range = {`FMC_BANK2_BASE, `FMC_BANK2_END};
         else
            bank_range = {`FMC_BANK3_BASE, `FMC_BANK3_END};
      end
   endfunction

   fmc_sync2 u_sync
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (supply_ok_i),
      .sync_o    (supply_s)
   );

   fmc_pulse_timer u_tmr
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .start_i   (start_q),
      .count_i   (tcount_q),
      .done_o    (tmr_done)
   );

   assign prot_act = prot_option_i & prot_q;
   assign blocked  = prot_act & ~acc_from_flash_i;
   assign even     = ~acc_addr_i[0];
   // Read view; bit2 reads busy, reserved reads zero
   assign ctl_rd   = {wmode_q, 5'b00000, bank_q, dword_q, tmr_q,
                      supply_s & wmode_q, fault_q, busy_q, ee_q, we_q};

   // ----------------------------------------
   // State decode
   // ----------------------------------------
   always @*
   begin
      op_live = 1'b0;
      case (state_q)
         ST_IDLE:
            op_live = 1'b0;
         ST_WAIT2:
            op_live = 1'b0;
         ST_RUN:
            op_live = 1'b1;
         ST_VER:
            op_live = 1'b0;
         default:
            op_live = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Access handling
   // ----------------------------------------
   always @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         state_q         <= ST_IDLE;
         wmode_q         <= 1'b0;
         we_q            <= 1'b0;
         ee_q            <= 1'b0;
         bank_q          <= 2'b00;
         dword_q         <= 1'b0;
         tmr_q           <= 2'b00;
         fault_q         <= 1'b0;
         busy_q          <= 1'b0;
         prot_q          <= `FMC_PROT_RESET;
         unlock_q        <= 1'b0;
         half_q          <= 1'b0;
         lo_word_q       <= 16'h0000;
         op_addr_q       <= 15'h0000;
         start_q         <= 1'b0;
         tcount_q        <= 20'h00000;
         acc_ack_o       <= 1'b0;
         acc_err_o       <= 1'b0;
         acc_rdata_o     <= 16'h0000;
         arr_rd_o        <= 1'b0;
         arr_addr_o      <= 15'h0000;
         arr_prog_o      <= 1'b0;
         arr_erase_o     <= 1'b0;
         arr_bank_o      <= 2'b00;
         arr_erase_lo_o  <= 15'h0000;
         arr_erase_hi_o  <= 15'h0000;
         arr_prog_data_o <= 32'h00000000;
         arr_dword_o     <= 1'b0;
         arr_pverify_o   <= 1'b0;
         arr_everify_o   <= 1'b0;
         write_mode_o    <= 1'b0;
         prot_active_o   <= 1'b0;
      end
      else
      begin
         acc_ack_o     <= acc_valid_i;
         acc_err_o     <= 1'b0;
         arr_rd_o      <= 1'b0;
         start_q       <= 1'b0;
         arr_prog_o    <= 1'b0;
         arr_erase_o   <= 1'b0;
         write_mode_o  <= wmode_q;
         prot_active_o <= prot_act;
         if (op_live & ~supply_s)
            fault_q <= 1'b1;
         if (tmr_done)
         begin
            busy_q  <= 1'b0;
            state_q <= ST_VER;
            arr_pverify_o <= ~ee_q;
            arr_everify_o <= ee_q;
         end
         if (acc_valid_i)
         begin
            if (blocked | busy_q)
            begin
               // Protected or mid-operation access refused
               acc_err_o   <= 1'b1;
               acc_rdata_o <= 16'h0000;
               unlock_q    <= 1'b0;
            end
            else if (!wmode_q)
            begin
               if (!acc_write_i)
               begin
                  arr_rd_o    <= 1'b1;
                  arr_addr_o  <= acc_addr_i;
                  acc_rdata_o <= arr_rdata_i;
                  unlock_q    <= 1'b0;
               end
               else if (acc_direct_i & even)
               begin
                  unlock_q <= 1'b1;
                  if (acc_from_flash_i & ~acc_wdata_i[`FMC_B_PROT])
                     prot_q <= 1'b0;
               end
               else if (!acc_direct_i & even & unlock_q)
               begin
                  wmode_q  <= 1'b1;
                  unlock_q <= 1'b0;
               end
               else
                  unlock_q <= 1'b0;
            end
            else if (acc_direct_i)
            begin
               // Virtual register inside flash window
               if (acc_write_i)
               begin
                  wmode_q <= acc_wdata_i[`FMC_B_WMODE];
                  bank_q  <= acc_wdata_i[`FMC_B_BANK_HI:`FMC_B_BANK_LO];
                  dword_q <= acc_wdata_i[`FMC_B_DWORD];
                  tmr_q   <= acc_wdata_i[`FMC_B_TMR_HI:`FMC_B_TMR_LO];
                  ee_q    <= acc_wdata_i[`FMC_B_EE];
                  we_q    <= acc_wdata_i[`FMC_B_WE];
                  half_q  <= 1'b0;
                  if (!acc_wdata_i[`FMC_B_WE])
                  begin
                     arr_pverify_o <= 1'b0;
                     arr_everify_o <= 1'b0;
                     state_q       <= ST_IDLE;
                  end
               end
               else
                  acc_rdata_o <= ctl_rd;
            end
            else if (acc_write_i & we_q)
            begin
               // Indirect array write launches operation, or latches first dword half
               if (ee_q)
               begin
                  {arr_erase_lo_o, arr_erase_hi_o} <= bank_range(bank_q);
                  arr_bank_o  <= bank_q;
                  arr_erase_o <= 1'b1;
                  busy_q      <= 1'b1;
                  fault_q     <= 1'b0;
                  tcount_q    <= pulse_duration(tmr_q);
                  start_q     <= 1'b1;
                  state_q     <= ST_RUN;
               end
               else if (dword_q & !half_q)
               begin
                  lo_word_q <= acc_wdata_i;
                  op_addr_q <= acc_addr_i;
                  half_q    <= 1'b1;
                  state_q   <= ST_WAIT2;
               end
               else
               begin
                  arr_prog_data_o <= dword_q ? {acc_wdata_i, lo_word_q}
                                             : {16'h0000, acc_wdata_i};
                  arr_addr_o  <= dword_q ? op_addr_q : acc_addr_i;
                  arr_dword_o <= dword_q;
                  arr_prog_o  <= 1'b1;
                  half_q      <= 1'b0;
                  busy_q      <= 1'b1;
                  fault_q     <= 1'b0;
                  tcount_q    <= pulse_duration(tmr_q);
                  start_q     <= 1'b1;
                  state_q     <= ST_RUN;
               end
            end
            else if (!acc_write_i)
            begin
               // Indirect read, verify reads under margin
               arr_rd_o    <= 1'b1;
               arr_addr_o  <= acc_addr_i;
               acc_rdata_o <= arr_rdata_i;
               half_q      <= 1'b0;
            end
            else
            begin
               acc_err_o   <= 1'b1;
               acc_rdata_o <= 16'h0000;
            end
         end
      end
   end
endmodule // fmc_flash_ctrl
`default_nettype wire

// >>> tb/fmc_monitor.sv
`default_nettype none
module fmc_monitor
(
   // Clock and reset
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   // Access
   input wire logic        acc_valid_i,
   input wire logic        acc_from_flash_i,
   input wire logic        acc_ack_o,
   input wire logic        acc_err_o,
   input wire logic [15:0] acc_rdata_o,
   // Operation
   input wire logic        arr_prog_o,
   input wire logic        arr_erase_o,
   input wire logic [1:0]  arr_bank_o,
   input wire logic [14:0] arr_erase_lo_o,
   input wire logic [14:0] arr_erase_hi_o,
   // Mode
   input wire logic        prot_option_i,
   input wire logic        write_mode_o,
   input wire logic        prot_active_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------
   // Port checks
   // ---------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   ack_after_req_a: assert property (acc_valid_i |=> acc_ack_o)
      else $error("ack missing after request");
   ack_only_req_a: assert property (!acc_valid_i |=> !acc_ack_o)
      else $error("ack without request");
   err_zero_data_a: assert property (acc_err_o |-> acc_ack_o && acc_rdata_o == 16'h0000)
      else $error("refusal without ack or with data");
   prot_refuse_a: assert property (
      acc_valid_i && prot_active_o && !acc_from_flash_i |=> acc_err_o)
      else $error("protected access not refused");
   prot_option_a: assert property (prot_active_o |-> prot_option_i)
      else $error("protection active without option");
   launch_wmode_a: assert property (arr_prog_o || arr_erase_o |-> write_mode_o)
      else $error("launch outside write mode");
   wmode_sticky_a: assert property (
      write_mode_o && !acc_valid_i && !$past(acc_valid_i) && !$past(acc_valid_i, 2)
      |=> write_mode_o)
      else $error("write mode lost without a write");
   erase_top_bank_a: assert property (
      arr_erase_o && arr_bank_o == 2'h3
      |-> arr_erase_lo_o == 15'h7800 && arr_erase_hi_o == 15'h7fff)
      else $error("bank 3 erase range wrong");
endmodule // fmc_monitor

bind fmc_flash_ctrl fmc_monitor fmc_monitor_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
   .acc_valid_i(acc_valid_i), .acc_from_flash_i(acc_from_flash_i), .acc_ack_o(acc_ack_o),
   .acc_err_o(acc_err_o), .acc_rdata_o(acc_rdata_o), .arr_prog_o(arr_prog_o),
   .arr_erase_o(arr_erase_o), .arr_bank_o(arr_bank_o), .arr_erase_lo_o(arr_erase_lo_o),
   .arr_erase_hi_o(arr_erase_hi_o), .prot_option_i(prot_option_i),
   .write_mode_o(write_mode_o), .prot_active_o(prot_active_o));
`default_nettype wire

// >>> tb/fmc_array_model.sv
`default_nettype none
module fmc_array_model
(
   // Address in, word out
   input  wire logic [14:0] addr_i,
   output logic      [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------
   // Fixed contents
   // ---------------
   assign rdata_o = {addr_i, 1'b0} ^ 16'ha5c3;
endmodule // fmc_array_model
`default_nettype wire

// >>> tb/fmc_flash_ctrl_tb_top.sv
`default_nettype none
module fmc_flash_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys_i = 0, reset_i = 1, acc_valid_i = 0, acc_write_i = 0;
   logic        acc_direct_i = 0, acc_from_flash_i = 0, prot_option_i = 1, supply_ok_i = 1;
   logic [14:0] acc_addr_i = 15'h0000, arr_addr_o, arr_erase_lo_o, arr_erase_hi_o;
   logic [15:0] acc_wdata_i = 16'h0000, arr_rdata_i, acc_rdata_o, rd;
   logic        acc_ack_o, acc_err_o, arr_rd_o, arr_prog_o, arr_erase_o, arr_dword_o;
   logic        arr_pverify_o, arr_everify_o, write_mode_o, prot_active_o, err, go, rs;
   logic [1:0]  arr_bank_o;
   logic [31:0] arr_prog_data_o;
   int          num_errors = 0, n_tests = 0, cyc = 0;
   // ---------------
   // Design and array
   // ---------------
   fmc_flash_ctrl fmc_flash_ctrl_i (.clk_sys_i, .reset_i, .acc_valid_i, .acc_write_i,
      .acc_direct_i, .acc_from_flash_i, .acc_addr_i, .acc_wdata_i, .acc_ack_o, .acc_err_o,
      .acc_rdata_o, .arr_rdata_i, .arr_rd_o, .arr_addr_o, .arr_prog_o, .arr_erase_o,
      .arr_bank_o, .arr_erase_lo_o, .arr_erase_hi_o, .arr_prog_data_o, .arr_dword_o,
      .arr_pverify_o, .arr_everify_o, .prot_option_i, .supply_ok_i, .write_mode_o,
      .prot_active_o);
   fmc_array_model fmc_array_model_i (.addr_i(acc_addr_i), .rdata_o(arr_rdata_i));
   initial
   begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) cyc <= cyc + 1;
   function automatic logic [15:0] aw(input logic [14:0] a);
      return {a, 1'b0} ^ 16'ha5c3;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic acc(input logic w, d, f, input logic [14:0] a, input logic [15:0] v);
      int k;
      @(posedge clk_sys_i);
      acc_valid_i <= 1'b1;
      acc_write_i <= w;
      acc_direct_i <= d;
      acc_from_flash_i <= f;
      acc_addr_i <= a;
      acc_wdata_i <= v;
      @(posedge clk_sys_i);
      acc_valid_i <= 1'b0;
      #1;
      for (k = 0; k < 4 && acc_ack_o !== 1'b1; k++)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      chk("ack", 1, k < 4);
      if (k == 4)
         end_sim();
      err = acc_err_o;
      rd = acc_rdata_o;
      go = arr_prog_o | arr_erase_o;
      rs = arr_rd_o;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic run_op(input logic [14:0] a, input logic [15:0] v, input int n,
      input logic [15:0] e);
      int k;
      int t0;
      acc(1, 0, 0, a, v);
      t0 = cyc;
      chk("launch", 1, go);
      err = 1'b1;
      for (k = 0; k < 9000 && err !== 1'b0; k++)
         acc(0, 1, 0, 15'h0010, 16'h0000);
      chk("pulse", 1, cyc - t0 >= n && cyc - t0 <= n + 6);
      if (k == 9000)
         end_sim();
      chk("reg", e, rd);
   endtask
   task automatic t_prot();
      chk("prot rst", 1, prot_active_o);
      acc(0, 0, 0, 15'h0100, 16'h0000);
      chk("ram err", 1, err);
      chk("no rd", 0, rs);
      acc(1, 1, 0, 15'h0200, 16'h0000);
      chk("ram clr", 1, prot_active_o);
      acc(1, 1, 1, 15'h0200, 16'h0000);
      chk("prot off", 0, prot_active_o);
      chk("wm kept", 0, write_mode_o);
      acc(0, 0, 0, 15'h0124, 16'h0000);
      chk("ram read", aw(15'h0124), rd);
      $display("t_prot done");
   endtask
   task automatic t_normal();
      acc(0, 1, 1, 15'h0040, 16'h0000);
      chk("dir read", aw(15'h0040), rd);
      chk("rd stb", 1, rs);
      chk("rd addr", 15'h0040, arr_addr_o);
      acc(1, 1, 0, 15'h0201, 16'h8001);
      acc(1, 0, 0, 15'h0300, 16'h0000);
      chk("odd key", 0, write_mode_o);
      acc(1, 1, 0, 15'h0200, 16'h0000);
      acc(0, 0, 0, 15'h0300, 16'h0000);
      acc(1, 0, 0, 15'h0300, 16'h0000);
      chk("split key", 0, write_mode_o);
      $display("t_normal done");
   endtask
   task automatic t_unlock();
      acc(1, 1, 0, 15'h0200, 16'h0000);
      acc(1, 0, 0, 15'h0300, 16'h0000);
      chk("wm set", 1, write_mode_o);
      repeat (100) @(posedge clk_sys_i);
      acc(0, 1, 0, 15'h0010, 16'h0000);
      chk("reg rst", 16'h8010, rd);
      acc(0, 0, 0, 15'h0300, 16'h0000);
      chk("ind read", aw(15'h0300), rd);
      $display("t_unlock done");
   endtask
   task automatic t_erase();
      logic [14:0] lo [4] = '{15'h0000, 15'h3000, 15'h6000, 15'h7800};
      logic [14:0] hi [4] = '{15'h2fff, 15'h5fff, 15'h77ff, 15'h7fff};
      for (int b = 0; b < 4; b++)
      begin
         acc(1, 1, 0, 15'h0010, {6'h20, b[1:0], 8'h03});
         run_op(lo[b], 16'h0000, 400, {6'h20, b[1:0], 8'h13});
         chk("bank", b[1:0], arr_bank_o);
         chk("lo", lo[b], arr_erase_lo_o);
         chk("hi", hi[b], arr_erase_hi_o);
         chk("ever", 1, arr_everify_o);
      end
      $display("t_erase done");
   endtask
   task automatic t_prog();
      acc(1, 1, 0, 15'h0010, 16'h8001);
      run_op(15'h0400, 16'h1234, 400, 16'h8011);
      chk("pdata", 16'h1234, arr_prog_data_o[15:0]);
      chk("pver", 1, arr_pverify_o);
      chk("word", 0, arr_dword_o);
      acc(1, 1, 0, 15'h0010, 16'h80a1);
      acc(1, 0, 0, 15'h0500, 16'h1111);
      chk("no launch", 0, go);
      run_op(15'h0502, 16'h2222, 4000, 16'h80b1);
      chk("dword", 32'h22221111, arr_prog_data_o);
      chk("dw", 1, arr_dword_o);
      chk("paddr", 15'h0500, arr_addr_o);
      $display("t_prog done");
   endtask
   task automatic t_fault();
      @(posedge clk_sys_i);
      supply_ok_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      acc(0, 1, 0, 15'h0010, 16'h0000);
      chk("low sup", 16'h80a1, rd);
      acc(1, 1, 0, 15'h0010, 16'h8001);
      run_op(15'h0600, 16'h0f0f, 400, 16'h8009);
      @(posedge clk_sys_i);
      supply_ok_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      acc(0, 1, 0, 15'h0010, 16'h0000);
      chk("fault", 16'h8019, rd);
      $display("t_fault done");
   endtask
   task automatic t_exit();
      acc(1, 1, 0, 15'h0010, 16'h8000);
      acc(1, 0, 0, 15'h0700, 16'h0000);
      chk("we zero", 1, err);
      chk("wm stays", 1, write_mode_o);
      acc(1, 1, 0, 15'h0010, 16'h0000);
      chk("wm exit", 0, write_mode_o);
      acc(0, 1, 0, 15'h0040, 16'h0000);
      chk("rom again", aw(15'h0040), rd);
      $display("t_exit done");
   endtask
   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      t_prot();
      t_normal();
      t_unlock();
      t_erase();
      t_prog();
      t_fault();
      t_exit();
      end_sim();
   end
endmodule // fmc_flash_ctrl_tb_top
`default_nettype wire
